// file: core/pgao_pkg.sv
package pgao_pkg;

  // ****************************************************************
  // Register map and field layout
  // ****************************************************************
  localparam int          PGAO_ADDR_W        = 16;
  localparam int          PGAO_PORT_W        = 8;
  localparam logic [15:0] PGAO_OFF_DIRECTION = 16'hFFC0;
  localparam logic [15:0] PGAO_OFF_LATCH     = 16'hFFC2;
  localparam logic [7:0]  PGAO_RST_DIRECTION = 8'h00;
  localparam logic [7:0]  PGAO_RST_LATCH     = 8'h00;
  localparam logic [7:0]  PGAO_DIR_READBACK  = 8'hFF;
  localparam logic [7:0]  PGAO_UNMAPPED_READ = 8'h00;

  // ****************************************************************
  // Operating modes
  // ****************************************************************
  localparam logic [1:0]  PGAO_MODE_EXPANDED = 2'h1;
  localparam logic [1:0]  PGAO_MODE_SINGLE_A = 2'h2;
  localparam logic [1:0]  PGAO_MODE_SINGLE_B = 2'h3;

  // ****************************************************************
  // Pin input synchroniser
  // ****************************************************************
  localparam int          PGAO_SYNC_STAGES   = 3;
  localparam logic [7:0]  PGAO_RST_SYNC      = 8'h00;

endpackage : pgao_pkg

// file: core/pgao_pin_sync.sv
module pgao_pin_sync
  import pgao_pkg::*;
#(
  parameter int WIDTH = PGAO_PORT_W
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] pin_async,
  output logic      [WIDTH-1:0] pin_level
);

  // ****************************************************************
  // Three-stage capture with agreement filter
  // ****************************************************************
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  wire  [WIDTH-1:0] agree_mask;
  wire  [WIDTH-1:0] next_pin_level;

  // A bit follows the pin only once the second and third stages agree.
  assign agree_mask     = ~(stage2 ^ stage3);
  assign next_pin_level = (agree_mask & stage3) | (~agree_mask & pin_level);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      stage1    <= '0;
      stage2    <= '0;
      stage3    <= '0;
      pin_level <= '0;
    end else begin
      stage1    <= pin_async;
      stage2    <= stage1;
      stage3    <= stage2;
      pin_level <= next_pin_level;
    end
  end

endmodule : pgao_pin_sync

// file: core/pgao_port.sv
// Function
// - Mode 1 pins carry address bits 7..0
// - Mode 1: direction 1 drives address, 0 inputs
// - Modes 2,3: direction 1 output, 0 input
// - Direction register eight bits, write-only, per pin
// - Direction register reads back all ones
// - Direction clears on reset and hardware standby
// - Software standby keeps direction and output state
// - Output latch eight bits, read and write
// - Output pins read back latched data
// - Input pins read back sampled pin level
// - Latch clears on reset, hardware standby; kept otherwise
// - Decode at 0xFFC0 and 0xFFC2, low sixteen bits
//
// Our own choice: the strobed register port.
module pgao_port
  import pgao_pkg::*;
#(
  parameter int PORT_W = PGAO_PORT_W,
  parameter int ADDR_W = PGAO_ADDR_W
) (
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic [1:0]        op_mode,
  input  wire logic              hw_standby,
  input  wire logic              sw_standby,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  output logic      [7:0]        reg_rdata,
  input  wire logic [7:0]        bus_addr_low,
  input  wire logic [PORT_W-1:0] pin_in,
  output logic      [PORT_W-1:0] pin_out,
  output logic      [PORT_W-1:0] pin_oe
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Chooses per bit between two values by the direction setting.
  function automatic logic [PORT_W-1:0] pick_by_dir(
    input logic [PORT_W-1:0] dir,
    input logic [PORT_W-1:0] when_set,
    input logic [PORT_W-1:0] when_clear
  );
    return (dir & when_set) | (~dir & when_clear);
  endfunction : pick_by_dir

  // Compares the low sixteen address bits with a register offset.
  function automatic logic addr_hit(
    input logic [ADDR_W-1:0] addr,
    input logic [15:0]       offset
  );
    return (addr[15:0] == offset);
  endfunction : addr_hit

  // A strobe counts only when it meets a matching address.
  function automatic logic strobe_hit(
    input logic              strobe,
    input logic [ADDR_W-1:0] addr,
    input logic [15:0]       offset
  );
    return strobe & addr_hit(addr, offset);
  endfunction : strobe_hit

  // Standby clear beats a write, and a write beats holding.
  function automatic logic [PORT_W-1:0] next_reg_value(
    input logic              clear,
    input logic              load,
    input logic [PORT_W-1:0] clear_value,
    input logic [PORT_W-1:0] load_value,
    input logic [PORT_W-1:0] current
  );
    logic [PORT_W-1:0] result;
    result = current;
    if (clear) begin
      result = clear_value;
    end else if (load) begin
      result = load_value;
    end
    return result;
  endfunction : next_reg_value

  // ****************************************************************
  // Standby control
  // ****************************************************************
  wire               standby_clear;

  assign standby_clear = hw_standby;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  wire               sel_direction;
  wire               sel_latch;
  wire               write_direction;
  wire               write_latch;
  wire               read_direction;
  wire               read_latch;
  wire               read_unmapped;

  assign sel_direction   = addr_hit(reg_addr, PGAO_OFF_DIRECTION);
  assign sel_latch       = addr_hit(reg_addr, PGAO_OFF_LATCH);

  assign write_direction = strobe_hit(reg_write, reg_addr, PGAO_OFF_DIRECTION);

  assign write_latch     = strobe_hit(reg_write, reg_addr, PGAO_OFF_LATCH);

  assign read_direction  = strobe_hit(reg_read, reg_addr, PGAO_OFF_DIRECTION);
  assign read_latch      = strobe_hit(reg_read, reg_addr, PGAO_OFF_LATCH);
  assign read_unmapped   = reg_read & ~sel_direction & ~sel_latch;

  // ****************************************************************
  // Direction register and output latch
  // ****************************************************************
  logic [PORT_W-1:0] port_direction;
  logic [PORT_W-1:0] port_output_latch;
  wire  [PORT_W-1:0] next_port_direction;
  wire  [PORT_W-1:0] next_port_output_latch;

  assign next_port_direction = next_reg_value(standby_clear, write_direction, PGAO_RST_DIRECTION[PORT_W-1:0],
                                              reg_wdata[PORT_W-1:0], port_direction);

  assign next_port_output_latch = next_reg_value(standby_clear, write_latch, PGAO_RST_LATCH[PORT_W-1:0],
                                                 reg_wdata[PORT_W-1:0], port_output_latch);

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      port_direction <= PGAO_RST_DIRECTION[PORT_W-1:0];
    end else begin
      port_direction <= next_port_direction;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      port_output_latch <= PGAO_RST_LATCH[PORT_W-1:0];
    end else begin
      port_output_latch <= next_port_output_latch;
    end
  end

  // ****************************************************************
  // Pin input sampling
  // ****************************************************************
  logic [PORT_W-1:0] pin_level;

  pgao_pin_sync #(
    .WIDTH     (PORT_W)
  ) u_pin_sync (
    .core_clk  (core_clk),
    .reset     (reset),
    .pin_async (pin_in),
    .pin_level (pin_level)
  );

  // ****************************************************************
  // Pin drive
  // ****************************************************************
  wire               mode_expanded;
  wire  [PORT_W-1:0] drive_value;
  wire  [PORT_W-1:0] next_pin_out;
  wire  [PORT_W-1:0] next_pin_oe;

  assign mode_expanded = (op_mode == PGAO_MODE_EXPANDED);

  assign drive_value = mode_expanded ? bus_addr_low[PORT_W-1:0] : port_output_latch;

  // pins stay inputs until software sets direction
  assign next_pin_oe  = port_direction;
  assign next_pin_out = pick_by_dir(port_direction, drive_value, {PORT_W{1'b0}});

  // Registered drive adds one cycle between a change and the pin.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pin_out <= '0;
      pin_oe  <= '0;
    end else begin
      pin_out <= next_pin_out;
      pin_oe  <= next_pin_oe;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  wire  [PORT_W-1:0] port_read_value;
  wire  [7:0]        next_reg_rdata;

  assign port_read_value = pick_by_dir(port_direction, port_output_latch, pin_level);

  assign next_reg_rdata = read_unmapped  ? PGAO_UNMAPPED_READ :
                          read_direction ? PGAO_DIR_READBACK :
                          read_latch     ? 8'(port_read_value) :
                                           PGAO_UNMAPPED_READ;

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= PGAO_UNMAPPED_READ;
    end else begin
      reg_rdata <= next_reg_rdata;
    end
  end

  // Software standby needs no logic: it gates nothing, so registers hold unless written while it is high.
  wire unused_sw_standby;
  assign unused_sw_standby = sw_standby;

endmodule : pgao_port

// file: sim/pgao_port_chk.sv
module pgao_port_chk
  import pgao_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic [1:0]  op_mode,
  input wire logic        hw_standby,
  input wire logic        sw_standby,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [7:0]  reg_rdata,
  input wire logic [7:0]  bus_addr_low,
  input wire logic [7:0]  pin_in,
  input wire logic [7:0]  pin_out,
  input wire logic [7:0]  pin_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  wire dir_wr = reg_write && reg_addr == PGAO_OFF_DIRECTION;
  wire rd_dir = reg_read && reg_addr == PGAO_OFF_DIRECTION;
  wire rd_lat = reg_read && reg_addr == PGAO_OFF_LATCH;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (reset);
  AST_DIR_READ: assert property (
    rd_dir |=> reg_rdata == PGAO_DIR_READBACK) else $error("Direction read not all ones");
  AST_UNMAPPED: assert property (
    reg_read && !rd_dir && !rd_lat |=> reg_rdata == PGAO_UNMAPPED_READ) else $error("Unmapped read data");
  AST_DIR_WRITE: assert property (
    dir_wr && !hw_standby ##1 !dir_wr && !hw_standby |=> pin_oe == $past(reg_wdata, 2))
    else $error("Direction write lost");
  AST_HW_CLEAR: assert property (
    hw_standby ##1 !dir_wr |=> pin_oe == 8'h00 && pin_out == 8'h00) else $error("Standby clear missing");
  AST_OUT_MASK: assert property (
    (pin_out & ~pin_oe) == 8'h00) else $error("Input pin driven");
  AST_ADDR_OUT: assert property (
    $past(op_mode) == PGAO_MODE_EXPANDED |-> pin_out == ($past(bus_addr_low) & pin_oe)) else $error("Address out");
  AST_LATCH_READ: assert property (
    rd_lat && op_mode != PGAO_MODE_EXPANDED |=> (reg_rdata & pin_oe) == (pin_out & pin_oe)) else $error("Latch read");
  AST_SW_HOLD: assert property (
    sw_standby && !reg_write && !hw_standby |=> $stable(pin_oe)) else $error("Standby lost pins");
  cover property (dir_wr ##2 pin_oe == 8'hFF);
  cover property (hw_standby [*2]);
  cover property (rd_lat ##1 reg_rdata != 8'h00);
endmodule : pgao_port_chk

// file: sim/pgao_pin_model.sv
module pgao_pin_model
  import pgao_pkg::*;
(
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] ext_level,
  output logic      [7:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Driven pins show the port's level, released pins the outside level.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : pgao_pin_model

// file: sim/port1_gpio_address_out_tb_top.sv
module port1_gpio_address_out_tb_top
  import pgao_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_count++; $display("Error %s exp %h seen %h", n, e, g); end end
  logic        core_clk = 0, reset = 1, hw_standby = 0, sw_standby = 0, reg_write = 0, reg_read = 0;
  logic [1:0]  op_mode = 2'h2;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0]  reg_wdata = 8'h00, bus_addr_low = 8'h00, ext_level = 8'h00, reg_rdata, pin_in, pin_out, pin_oe, d, l;
  int          err_count = 0, checked = 0, cyc = 0;
  pgao_port dut_u (.core_clk, .reset, .op_mode, .hw_standby, .sw_standby, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .bus_addr_low, .pin_in, .pin_out, .pin_oe);
  pgao_pin_model pins_u (.pin_out, .pin_oe, .ext_level, .pin_in);
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("Checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e, input string n);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1 `CHK(n, e, reg_rdata)
  endtask : rd
  function automatic logic [7:0] port_read(input logic [7:0] dv, input logic [7:0] lv, input logic [7:0] ev);
    return (dv & lv) | (~dv & ev);
  endfunction : port_read
  initial begin
    void'($urandom(32'hB1811603));
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    repeat (5) @(posedge core_clk);
    rd(PGAO_OFF_LATCH, PGAO_RST_LATCH, "reset_read");
    rd(PGAO_OFF_DIRECTION, PGAO_DIR_READBACK, "dir_read");
    rd(16'hFFC1, PGAO_UNMAPPED_READ, "unmapped");
    $display("Test reset done");
    for (int i = 0; i < 24; i++) begin
      @(posedge core_clk);
      d = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
      l = 8'($urandom);
      op_mode      <= 2'(i % 3 + 1);
      bus_addr_low <= 8'($urandom);
      ext_level    <= 8'($urandom);
      wr(PGAO_OFF_DIRECTION, d);
      wr(PGAO_OFF_LATCH, l);
      repeat (5) @(posedge core_clk);
      #1 `CHK("pin_oe", d, pin_oe)
      `CHK("pin_out", (op_mode == PGAO_MODE_EXPANDED ? bus_addr_low : l) & d, pin_out)
      rd(PGAO_OFF_LATCH, port_read(d, l, ext_level), "port_read");
    end
    $display("Test random done");
    @(posedge core_clk);
    sw_standby <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1 `CHK("sw_oe", d, pin_oe)
    rd(PGAO_OFF_LATCH, port_read(d, l, ext_level), "sw_latch");
    @(posedge core_clk);
    sw_standby <= 1'b0;
    hw_standby <= 1'b1;
    ext_level  <= 8'h00;
    repeat (2) @(posedge core_clk);
    hw_standby <= 1'b0;
    repeat (5) @(posedge core_clk);
    #1 `CHK("hw_oe", PGAO_RST_DIRECTION, pin_oe)
    rd(PGAO_OFF_LATCH, PGAO_RST_LATCH, "hw_latch");
    $display("Test standby done");
    give_verdict();
  end
endmodule : port1_gpio_address_out_tb_top

bind pgao_port pgao_port_chk chk_u (.core_clk, .reset, .op_mode, .hw_standby, .sw_standby, .reg_addr, .reg_wdata,
  .reg_write, .reg_read, .reg_rdata, .bus_addr_low, .pin_in, .pin_out, .pin_oe);
